// ===== core/dmes_pkg.sv
// Overview of operation
// - Background debug ends only on power-on or hard reset assertion.
// - Reduced trace port uses one input lane and two output lanes.
// - Full trace port uses two input lanes and eight output lanes.
// - Message input bit zero high at trace enable selects full port width.
// - Message input bit zero low at trace enable selects reduced port width.
package dmes_pkg;

  // ==========================================================================
  // Timing counts in system clocks
  localparam int unsigned DATA_SAMPLE_CLKS  = 8;
  localparam int unsigned STRAP_SETUP_CLKS  = 4;
  localparam int unsigned SAMPLE_CNT_W      = 4;

  // ==========================================================================
  // Synchronised pin vector layout
  localparam int unsigned PIN_W             = 10;
  localparam int unsigned PIN_POR_N         = 0;
  localparam int unsigned PIN_HARD_N        = 1;
  localparam int unsigned PIN_SOFT_N        = 2;
  localparam int unsigned PIN_DSCLK         = 3;
  localparam int unsigned PIN_DSDATA        = 4;
  localparam int unsigned PIN_COMP_RST      = 5;
  localparam int unsigned PIN_MODE_SEL      = 6;
  localparam int unsigned PIN_WIDTH_STRAP   = 7;
  localparam int unsigned PIN_MSG_IN_LO     = 8;
  localparam int unsigned PIN_MSG_IN_HI     = 9;

  // ==========================================================================
  // Port widths and lane masks
  localparam int unsigned MSG_IN_W          = 2;
  localparam int unsigned MSG_OUT_W         = 8;
  localparam logic [1:0]  IN_LANES_REDUCED  = 2'h1;
  localparam logic [1:0]  IN_LANES_FULL     = 2'h3;
  localparam logic [7:0]  OUT_LANES_REDUCED = 8'h03;
  localparam logic [7:0]  OUT_LANES_FULL    = 8'hFF;

  // ==========================================================================
  // Reset values
  localparam logic [PIN_W-1:0] PIN_RESET    = 10'h007;

  // ==========================================================================
  // State encodings
  typedef enum logic [2:0] {
    BGD_OFF  = 3'h1,
    BGD_WAIT = 3'h2,
    BGD_ON   = 3'h4
  } dmes_bgd_state_t;

  typedef enum logic [2:0] {
    TRC_OFF   = 3'h1,
    TRC_ARMED = 3'h2,
    TRC_ON    = 3'h4
  } dmes_trc_state_t;

endpackage

// ===== core/dmes_sync.sv
`timescale 1ns/10ps
module dmes_sync #(
  parameter int unsigned         WIDTH = 1,
  parameter logic [WIDTH-1:0]    INIT  = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Two-stage synchroniser, first stage feeds only the second
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta     <= INIT;
      sync_out <= INIT;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // dmes_sync

// ===== core/dmes_top.sv
`timescale 1ns/10ps
module dmes_top (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic       power_on_reset_line_n_in,
  input  wire logic       hard_reset_line_n_in,
  input  wire logic       soft_reset_line_n_in,
  input  wire logic       debug_serial_clock_pin_in,
  input  wire logic       debug_serial_data_in_in,
  input  wire logic       compliance_reset_in_pin_in,
  input  wire logic       mode_select_event_in_pin_in,
  input  wire logic       message_data_in_bit0_in,
  input  wire logic [1:0] message_data_in_pins_in,
  input  wire logic [7:0] message_data_out_core_in,
  output logic            background_debug_mode_out,
  output logic            debug_clock_mode_out,
  output logic            realtime_debug_unit_active_out,
  output logic            trace_full_port_out,
  output logic [1:0]      trace_in_lane_en_out,
  output logic [7:0]      trace_out_lane_en_out,
  output logic [1:0]      message_data_in_core_out,
  output logic [7:0]      message_data_out_pins_out
);

  // ==========================================================================
  // Reset release
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ==========================================================================
  // Pin synchronisation
  logic [dmes_pkg::PIN_W-1:0] pins_raw;
  logic [dmes_pkg::PIN_W-1:0] pins;

  assign pins_raw = {message_data_in_pins_in, message_data_in_bit0_in, mode_select_event_in_pin_in,
                     compliance_reset_in_pin_in, debug_serial_data_in_in, debug_serial_clock_pin_in,
                     soft_reset_line_n_in, hard_reset_line_n_in, power_on_reset_line_n_in};

  dmes_sync #(
    .WIDTH (dmes_pkg::PIN_W),
    .INIT  (dmes_pkg::PIN_RESET)
  ) u_pin_sync (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n),
    .async_in (pins_raw),
    .sync_out (pins)
  );

  // ==========================================================================
  // Edge detection
  logic [dmes_pkg::PIN_W-1:0] pins_prev;
  logic [dmes_pkg::PIN_W-1:0] next_pins_prev;
  logic                       por_assert;
  logic                       hard_assert;
  logic                       kill_debug;
  logic                       por_negate;
  logic                       soft_negate;
  logic                       comp_rise;

  always_comb begin
    next_pins_prev = pins;
    por_assert     = pins_prev[dmes_pkg::PIN_POR_N] & ~pins[dmes_pkg::PIN_POR_N];
    hard_assert    = pins_prev[dmes_pkg::PIN_HARD_N] & ~pins[dmes_pkg::PIN_HARD_N];
    kill_debug     = ~pins[dmes_pkg::PIN_POR_N] | ~pins[dmes_pkg::PIN_HARD_N] | por_assert | hard_assert;
    por_negate     = ~pins_prev[dmes_pkg::PIN_POR_N] & pins[dmes_pkg::PIN_POR_N];
    soft_negate    = ~pins_prev[dmes_pkg::PIN_SOFT_N] & pins[dmes_pkg::PIN_SOFT_N];
    comp_rise      = ~pins_prev[dmes_pkg::PIN_COMP_RST] & pins[dmes_pkg::PIN_COMP_RST];
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev <= dmes_pkg::PIN_RESET;
    end else begin
      pins_prev <= next_pins_prev;
    end
  end

  // ==========================================================================
  // Background debug entry
  dmes_pkg::dmes_bgd_state_t         bgd_state;
  dmes_pkg::dmes_bgd_state_t         next_bgd_state;
  logic [dmes_pkg::SAMPLE_CNT_W-1:0] bgd_cnt;
  logic [dmes_pkg::SAMPLE_CNT_W-1:0] next_bgd_cnt;
  logic                              clk_mode;
  logic                              next_clk_mode;

  always_comb begin
    next_bgd_state = bgd_state;
    next_bgd_cnt   = bgd_cnt;
    next_clk_mode  = clk_mode;
    unique case (bgd_state)
      dmes_pkg::BGD_OFF: begin
        if (soft_negate && pins[dmes_pkg::PIN_DSCLK] && !kill_debug) begin
          next_bgd_state = dmes_pkg::BGD_WAIT;
          next_bgd_cnt   = '0;
        end
      end
      dmes_pkg::BGD_WAIT: begin
        next_bgd_cnt = bgd_cnt + 1'b1;
        if (bgd_cnt == dmes_pkg::SAMPLE_CNT_W'(dmes_pkg::DATA_SAMPLE_CLKS - 1)) begin
          next_clk_mode  = pins[dmes_pkg::PIN_DSDATA];
          next_bgd_state = dmes_pkg::BGD_ON;
        end
      end
      dmes_pkg::BGD_ON: begin
        next_bgd_state = dmes_pkg::BGD_ON;
      end
      default: begin
        next_bgd_state = dmes_pkg::BGD_OFF;
      end
    endcase
    if (kill_debug) begin
      next_bgd_state = dmes_pkg::BGD_OFF;
      next_bgd_cnt   = '0;
      next_clk_mode  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      bgd_state <= dmes_pkg::BGD_OFF;
      bgd_cnt   <= '0;
      clk_mode  <= 1'b0;
    end else begin
      bgd_state <= next_bgd_state;
      bgd_cnt   <= next_bgd_cnt;
      clk_mode  <= next_clk_mode;
    end
  end

  // ==========================================================================
  // Trace port entry
  dmes_pkg::dmes_trc_state_t                trc_state;
  dmes_pkg::dmes_trc_state_t                next_trc_state;
  logic [dmes_pkg::STRAP_SETUP_CLKS-1:0]    sel_hist;
  logic [dmes_pkg::STRAP_SETUP_CLKS-1:0]    next_sel_hist;
  logic [dmes_pkg::STRAP_SETUP_CLKS-1:0]    wid_hist;
  logic [dmes_pkg::STRAP_SETUP_CLKS-1:0]    next_wid_hist;
  logic                                     full_port;
  logic                                     next_full_port;
  logic                                     strap_ok;

  always_comb begin
    next_trc_state = trc_state;
    next_full_port = full_port;
    next_sel_hist  = {sel_hist[dmes_pkg::STRAP_SETUP_CLKS-2:0], pins[dmes_pkg::PIN_MODE_SEL]};
    next_wid_hist  = {wid_hist[dmes_pkg::STRAP_SETUP_CLKS-2:0], pins[dmes_pkg::PIN_WIDTH_STRAP]};
    strap_ok       = (sel_hist == '0) && ((wid_hist == '0) || (&wid_hist));
    unique case (trc_state)
      dmes_pkg::TRC_OFF: begin
        if (por_negate && !pins[dmes_pkg::PIN_COMP_RST]) begin
          next_trc_state = dmes_pkg::TRC_ARMED;
        end
      end
      dmes_pkg::TRC_ARMED: begin
        if (comp_rise) begin
          if (strap_ok) begin
            next_trc_state = dmes_pkg::TRC_ON;
            next_full_port = wid_hist[dmes_pkg::STRAP_SETUP_CLKS-1];
          end else begin
            next_trc_state = dmes_pkg::TRC_OFF;
          end
        end
      end
      dmes_pkg::TRC_ON: begin
        next_trc_state = dmes_pkg::TRC_ON;
      end
      default: begin
        next_trc_state = dmes_pkg::TRC_OFF;
      end
    endcase
    if (kill_debug) begin
      next_trc_state = dmes_pkg::TRC_OFF;
      next_full_port = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      trc_state <= dmes_pkg::TRC_OFF;
      sel_hist  <= '1;
      wid_hist  <= '0;
      full_port <= 1'b0;
    end else begin
      trc_state <= next_trc_state;
      sel_hist  <= next_sel_hist;
      wid_hist  <= next_wid_hist;
      full_port <= next_full_port;
    end
  end

  // ==========================================================================
  // Lane masking and outputs
  logic       next_bgd_out;
  logic       next_clk_mode_out;
  logic       next_trc_out;
  logic       next_full_out;
  logic [1:0] next_in_lanes;
  logic [7:0] next_out_lanes;
  logic [1:0] next_msg_in;
  logic [7:0] next_msg_out;

  always_comb begin
    next_bgd_out      = (next_bgd_state == dmes_pkg::BGD_ON);
    next_clk_mode_out = next_clk_mode;
    next_trc_out      = (next_trc_state == dmes_pkg::TRC_ON);
    next_full_out     = next_trc_out & next_full_port;
    next_in_lanes     = '0;
    next_out_lanes    = '0;
    if (next_trc_out) begin
      next_in_lanes  = next_full_port ? dmes_pkg::IN_LANES_FULL : dmes_pkg::IN_LANES_REDUCED;
      next_out_lanes = next_full_port ? dmes_pkg::OUT_LANES_FULL : dmes_pkg::OUT_LANES_REDUCED;
    end
    next_msg_in  = pins[dmes_pkg::PIN_MSG_IN_HI:dmes_pkg::PIN_MSG_IN_LO] & next_in_lanes;
    next_msg_out = message_data_out_core_in & next_out_lanes;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      background_debug_mode_out      <= 1'b0;
      debug_clock_mode_out           <= 1'b0;
      realtime_debug_unit_active_out <= 1'b0;
      trace_full_port_out            <= 1'b0;
      trace_in_lane_en_out           <= '0;
      trace_out_lane_en_out          <= '0;
      message_data_in_core_out       <= '0;
      message_data_out_pins_out      <= '0;
    end else begin
      background_debug_mode_out      <= next_bgd_out;
      debug_clock_mode_out           <= next_clk_mode_out;
      realtime_debug_unit_active_out <= next_trc_out;
      trace_full_port_out            <= next_full_out;
      trace_in_lane_en_out           <= next_in_lanes;
      trace_out_lane_en_out          <= next_out_lanes;
      message_data_in_core_out       <= next_msg_in;
      message_data_out_pins_out      <= next_msg_out;
    end
  end

endmodule // dmes_top

// ===== dv/dmes_chk.sv
`timescale 1ns/10ps
module dmes_chk (
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic       power_on_reset_line_n_in,
  input wire logic       hard_reset_line_n_in,
  input wire logic       soft_reset_line_n_in,
  input wire logic       debug_serial_clock_pin_in,
  input wire logic       debug_serial_data_in_in,
  input wire logic       compliance_reset_in_pin_in,
  input wire logic       mode_select_event_in_pin_in,
  input wire logic       message_data_in_bit0_in,
  input wire logic [1:0] message_data_in_pins_in,
  input wire logic [7:0] message_data_out_core_in,
  input wire logic       background_debug_mode_out,
  input wire logic       debug_clock_mode_out,
  input wire logic       realtime_debug_unit_active_out,
  input wire logic       trace_full_port_out,
  input wire logic [1:0] trace_in_lane_en_out,
  input wire logic [7:0] trace_out_lane_en_out,
  input wire logic [1:0] message_data_in_core_out,
  input wire logic [7:0] message_data_out_pins_out
);
  // ==========================================================================
  // Pin reset history
  logic [4:0] rst_hist;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_hist <= 5'h00;
    end else begin
      rst_hist <= {rst_hist[3:0], power_on_reset_line_n_in & hard_reset_line_n_in};
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // ==========================================================================
  // Properties
  sequence s_bgd_req;
    $past(soft_reset_line_n_in, 9) && !$past(soft_reset_line_n_in, 13) && $past(debug_serial_clock_pin_in, 11)
      && (debug_clock_mode_out == $past(debug_serial_data_in_in, 3));
  endsequence
  sequence s_trc_req;
    $past(compliance_reset_in_pin_in, 3) && !$past(mode_select_event_in_pin_in, 7)
      && (trace_full_port_out == $past(message_data_in_bit0_in, 7));
  endsequence
  property p_bgd_entry; $rose(background_debug_mode_out) |-> s_bgd_req; endproperty
  a_bgd_entry: assert property (p_bgd_entry) else $error("debug entry without request");
  property p_trc_entry; $rose(realtime_debug_unit_active_out) |-> s_trc_req; endproperty
  a_trc_entry: assert property (p_trc_entry) else $error("trace entry without straps");
  property p_bgd_hold; $past(background_debug_mode_out) && ($changed(background_debug_mode_out)
    || $changed(debug_clock_mode_out)) |-> rst_hist != 5'h1F; endproperty
  a_bgd_hold: assert property (p_bgd_hold) else $error("debug mode left without reset");
  property p_trc_hold; $past(realtime_debug_unit_active_out) && ($changed(realtime_debug_unit_active_out)
    || $changed(trace_full_port_out)) |-> rst_hist != 5'h1F; endproperty
  a_trc_hold: assert property (p_trc_hold) else $error("trace mode changed without reset");
  property p_lane_full; realtime_debug_unit_active_out && trace_full_port_out
    |-> trace_in_lane_en_out == 2'h3 && trace_out_lane_en_out == 8'hFF; endproperty
  a_lane_full: assert property (p_lane_full) else $error("full port lanes wrong");
  property p_lane_red; realtime_debug_unit_active_out && !trace_full_port_out
    |-> trace_in_lane_en_out == 2'h1 && trace_out_lane_en_out == 8'h03; endproperty
  a_lane_red: assert property (p_lane_red) else $error("reduced port lanes wrong");
  property p_lane_off; !realtime_debug_unit_active_out
    |-> !trace_full_port_out && trace_in_lane_en_out == 2'h0 && trace_out_lane_en_out == 8'h00; endproperty
  a_lane_off: assert property (p_lane_off) else $error("lanes open while trace off");
  property p_out_mask; $stable(trace_out_lane_en_out)
    |-> message_data_out_pins_out == ($past(message_data_out_core_in) & trace_out_lane_en_out); endproperty
  a_out_mask: assert property (p_out_mask) else $error("output lanes not masked");
endmodule // dmes_chk

bind dmes_top dmes_chk chk_u (.*);

// ===== dv/dmes_tb.sv
`timescale 1ns/10ps
module testbench;
  logic       clk_sys_in, nrst_in, power_on_reset_line_n_in, hard_reset_line_n_in, soft_reset_line_n_in;
  logic       debug_serial_clock_pin_in, debug_serial_data_in_in, compliance_reset_in_pin_in;
  logic       mode_select_event_in_pin_in, message_data_in_bit0_in, background_debug_mode_out;
  logic       debug_clock_mode_out, realtime_debug_unit_active_out, trace_full_port_out;
  logic [1:0] message_data_in_pins_in, trace_in_lane_en_out, message_data_in_core_out;
  logic [7:0] message_data_out_core_in, trace_out_lane_en_out, message_data_out_pins_out;
  int         fail_count, total_checks;

  dmes_top dut_u (.*);
  dmes_tool tool_u (
    .clk_in(clk_sys_in), .power_on_reset_line_n_out(power_on_reset_line_n_in),
    .hard_reset_line_n_out(hard_reset_line_n_in), .soft_reset_line_n_out(soft_reset_line_n_in),
    .debug_serial_clock_pin_out(debug_serial_clock_pin_in), .debug_serial_data_in_out(debug_serial_data_in_in),
    .compliance_reset_in_pin_out(compliance_reset_in_pin_in),
    .mode_select_event_in_pin_out(mode_select_event_in_pin_in),
    .message_data_in_bit0_out(message_data_in_bit0_in), .message_data_in_pins_out(message_data_in_pins_in)
  );
  initial clk_sys_in = 1'b0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  // ==========================================================================
  // Compare and finish
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_bgd();
    tool_u.bgd_req(1'b0, 1'b1);
    chk1(background_debug_mode_out, 1'b0);
    tool_u.bgd_req(1'b1, 1'b1);
    chk1(background_debug_mode_out, 1'b1);
    chk1(debug_clock_mode_out, 1'b1);
    tool_u.bgd_req(1'b1, 1'b0);
    chk1(background_debug_mode_out, 1'b1);
    chk1(debug_clock_mode_out, 1'b1);
    tool_u.hard_rst();
    chk1(background_debug_mode_out, 1'b0);
    tool_u.bgd_req(1'b1, 1'b0);
    chk1(background_debug_mode_out, 1'b1);
    chk1(debug_clock_mode_out, 1'b0);
  endtask
  task automatic t_trace(input logic full, input int setup);
    logic [7:0] lanes;
    lanes = full ? 8'hFF : 8'h03;
    tool_u.trace_req(full, 1'b0, setup);
    chk1(background_debug_mode_out, 1'b0);
    chk1(realtime_debug_unit_active_out, 1'b1);
    chk1(trace_full_port_out, full);
    chk8(8'(trace_in_lane_en_out), full ? 8'h03 : 8'h01);
    chk8(trace_out_lane_en_out, lanes);
    chk8(8'(message_data_in_core_out), full ? 8'h03 : 8'h01);
    chk8(message_data_out_pins_out, 8'hA5 & lanes);
  endtask
  task automatic t_trace_refused();
    tool_u.trace_req(1'b1, 1'b1, 6);
    chk1(realtime_debug_unit_active_out, 1'b0);
    chk8(message_data_out_pins_out, 8'h00);
    chk8(8'(message_data_in_core_out), 8'h00);
    tool_u.trace_req(1'b1, 1'b0, 3);
    chk1(realtime_debug_unit_active_out, 1'b0);
    chk8(trace_out_lane_en_out, 8'h00);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    nrst_in = 1'b0;
    message_data_out_core_in = 8'hA5;
    repeat (10) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    repeat (6) @(posedge clk_sys_in);
    #1;
    t_bgd();
    t_trace(1'b1, 6);
    t_trace(1'b0, 4);
    t_trace_refused();
    end_sim();
  end
  initial begin
    repeat (4000) @(posedge clk_sys_in);
    fail_count++;
    end_sim();
  end
endmodule // testbench

// ===== dv/dmes_tool.sv
`timescale 1ns/10ps
module dmes_tool (
  input  wire logic       clk_in,
  output logic            power_on_reset_line_n_out = 1'b1,
  output logic            hard_reset_line_n_out = 1'b1,
  output logic            soft_reset_line_n_out = 1'b1,
  output logic            debug_serial_clock_pin_out = 1'b0,
  output logic            debug_serial_data_in_out = 1'b0,
  output logic            compliance_reset_in_pin_out = 1'b0,
  output logic            mode_select_event_in_pin_out = 1'b1,
  output logic            message_data_in_bit0_out = 1'b0,
  output logic [1:0]      message_data_in_pins_out = 2'h0
);
  // ==========================================================================
  // Strap sequences
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic bgd_req(input logic clk_lvl, input logic data_lvl);
    soft_reset_line_n_out = 1'b0;
    debug_serial_clock_pin_out = clk_lvl;
    debug_serial_data_in_out = ~data_lvl;
    tick(4);
    soft_reset_line_n_out = 1'b1;
    tick(8);
    debug_serial_data_in_out = data_lvl;
    tick(7);
    repeat (2) begin
      tick(12);
      debug_serial_clock_pin_out = ~debug_serial_clock_pin_out;
      tick(13);
      debug_serial_clock_pin_out = ~debug_serial_clock_pin_out;
    end
    debug_serial_clock_pin_out = 1'b0;
    tick(1);
  endtask
  task automatic hard_rst();
    hard_reset_line_n_out = 1'b0;
    tick(4);
    hard_reset_line_n_out = 1'b1;
    tick(4);
  endtask
  task automatic trace_req(input logic full_lvl, input logic sel_lvl, input int setup);
    compliance_reset_in_pin_out = 1'b0;
    power_on_reset_line_n_out = 1'b0;
    mode_select_event_in_pin_out = 1'b1;
    message_data_in_bit0_out = ~full_lvl;
    tick(4);
    power_on_reset_line_n_out = 1'b1;
    tick(2);
    mode_select_event_in_pin_out = sel_lvl;
    message_data_in_bit0_out = full_lvl;
    tick(setup);
    compliance_reset_in_pin_out = 1'b1;
    message_data_in_pins_out = 2'h3;
    tick(8);
    message_data_in_bit0_out = ~full_lvl;
    tick(4);
  endtask
endmodule // dmes_tool
